/* pkg/rx_sys_port_defines.svh */
// Register indices, field positions, reset values of the receive port
`ifndef RX_SYS_PORT_DEFINES_SVH
`define RX_SYS_PORT_DEFINES_SVH

// Register indices; byte address is four times the index
`define RXS_IDX_SYSCFG 10'h010
`define RXS_IDX_STATUS 10'h012
`define RXS_IDX_FLOAT_BASE 10'h023
`define RXS_IDX_LINK_STRIDE 10'h040

// System configuration fields
`define RXS_MODE_LO 0
`define RXS_MODE_HI 1
`define RXS_SHARED_BIT 4

// Per-link driver float field
`define RXS_FLOAT_BIT 4

// Status fields
`define RXS_STAT_SEEN_LO 0
`define RXS_STAT_SEEN_HI 3
`define RXS_STAT_GFLOAT_BIT 4
`define RXS_STAT_MODE_LO 5
`define RXS_STAT_MODE_HI 6

// Reset values and mode write codes
`define RXS_SHARED_RST 1'b0
`define RXS_FLOAT_RST 4'h0
`define RXS_MODE_CODE_SLAVE 2'h1
`define RXS_MODE_CODE_MUX 2'h2

// Serial slot shape
`define RXS_SLOT_BITS 8
`define RXS_SLOT_LAST 3'h7
`define RXS_LINKS 4

`endif

/* pkg/rx_sys_port_pkg.sv */
// Types shared by the receive system port files
package rx_sys_port_pkg;

  typedef enum logic [1:0] {
    MODE_MASTER,
    MODE_SLAVE,
    MODE_MUX
  } rx_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] sig;
  } slot_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : rx_sys_port_pkg

/* core/rx_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module rx_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;
endmodule : rx_sync2

/* core/rx_slot_serializer.sv */
// Slot serializer: data byte and signaling byte, MSB first
`timescale 1ns/1ps
`include "rx_sys_port_defines.svh"
module rx_slot_serializer
  import rx_sys_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire slot_t load_slot,
  output logic data_bit,
  output logic sig_bit,
  output logic loaded
);
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] sig_q;
  logic [7:0] sig_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic loaded_q;
  logic loaded_d;

  always_comb begin
    data_d = data_q;
    sig_d = sig_q;
    cnt_d = cnt_q;
    loaded_d = 1'b0;
    if (step) begin
      if (cnt_q == `RXS_SLOT_LAST) begin
        data_d = load_slot.data;
        // Signaling in the last four bit times of the slot
        sig_d = {4'h0, load_slot.sig};
        cnt_d = 3'h0;
        loaded_d = 1'b1;
      end else begin
        data_d = {data_q[6:0], 1'b0};
        sig_d = {sig_q[6:0], 1'b0};
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  // Counter starts at the last bit so the first step loads a slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 8'h00;
      sig_q <= 8'h00;
      cnt_q <= `RXS_SLOT_LAST;
      loaded_q <= 1'b0;
    end else begin
      data_q <= data_d;
      sig_q <= sig_d;
      cnt_q <= cnt_d;
      loaded_q <= loaded_d;
    end
  end

  assign data_bit = data_q[7];
  assign sig_bit = sig_q[7];
  assign loaded = loaded_q;
endmodule : rx_slot_serializer

/* core/rx_sys_port.sv */
// Receive system side output port with APB control and driver float
//
// Behaviour
// - Global float pin high floats line drivers of all four links.
// - Per-link float bit set floats only that link's line drivers.
// - Master mode: link data updates on that link's own system clock.
// - Slave mode: shared select picks own clock or link one's clock.
// - Multiplexed mode: all four links byte-interleaved on one data pin.
// - Multiplexed outputs update on the multiplexed system clock edge.
// - Primary and backup multiplexed outputs carry identical data.
// - Signaling sits in bits five to eight of each slot, slot aligned.
// - Master mode: signaling updates on that link's own system clock.
// - Slave mode: shared select also steers the signaling clock.
// - Multiplexed signaling interleaved, aligned with multiplexed data.
// - Master mode drives a gapped system clock per link.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "rx_sys_port_defines.svh"
module rx_sys_port
  import rx_sys_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_driver_float_pin,
  input wire line_pair_t [3:0] tx_line_in,
  output logic [3:0] line_tx_positive,
  output logic [3:0] line_tx_negative,
  output logic [3:0] line_tx_oe,
  input wire logic mux_rx_sys_clock,
  input wire logic [3:0] rx_sys_clock_link_in,
  output logic [3:0] rx_sys_clock_link,
  output logic [3:0] rx_sys_clock_oe,
  input wire logic [3:0] rx_gap,
  input wire slot_t [3:0] slot_in,
  output logic [3:0] slot_req,
  output logic [3:0] rx_sys_data_out,
  output logic [3:0] rx_signaling_out,
  output logic [3:0] rx_sys_oe,
  output logic mux_rx_data_primary,
  output logic mux_rx_data_backup,
  output logic mux_rx_signaling_primary,
  output logic mux_rx_signaling_backup,
  output logic mux_rx_oe
);

  // ---------------- Register side, pclk domain ----------------
  logic [9:0] idx;
  logic setup, access, wr, hit_cfg, hit_stat, mapped, gfloat_s;
  logic [3:0] hit_float, act_s, act_prev_q, act_prev_d, act_new, seen_clr;

  rx_mode_t mode_q, mode_d;
  logic shared_q, shared_d, pready_q, pready_d, pslverr_q, pslverr_d;
  logic [3:0] float_q, float_d, seen_q, seen_d;
  logic [31:0] prdata_q, prdata_d, rd_word;
  logic [3:0] tx_pos_q, tx_pos_d, tx_neg_q, tx_neg_d, tx_oe_q, tx_oe_d;

  assign idx = apb_in.paddr[11:2];
  assign setup = apb_in.psel & ~apb_in.penable;
  assign access = apb_in.psel & apb_in.penable & pready_q;
  assign wr = access & apb_in.pwrite;
  assign hit_cfg = (idx == `RXS_IDX_SYSCFG);
  assign hit_stat = (idx == `RXS_IDX_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < `RXS_LINKS; gi++) begin : g_float_hit
      localparam logic [9:0] FloatIdx =
        10'(`RXS_IDX_FLOAT_BASE + gi * `RXS_IDX_LINK_STRIDE);
      assign hit_float[gi] = (idx == FloatIdx);
    end
  endgenerate

  assign mapped = hit_cfg | hit_stat | (|hit_float);

  rx_sync2 #(.WIDTH(1)) u_gfloat_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(global_driver_float_pin),
    .q(gfloat_s)
  );

  // Activity toggles from the link domain become per-link events
  always_comb begin
    act_prev_d = act_s;
    act_new = act_s ^ act_prev_q;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cfg) begin
      rd_word[`RXS_MODE_HI:`RXS_MODE_LO] = mode_q;
      rd_word[`RXS_SHARED_BIT] = shared_q;
    end
    if (hit_stat) begin
      rd_word[`RXS_STAT_SEEN_HI:`RXS_STAT_SEEN_LO] = seen_q;
      rd_word[`RXS_STAT_GFLOAT_BIT] = gfloat_s;
      rd_word[`RXS_STAT_MODE_HI:`RXS_STAT_MODE_LO] = mode_q;
    end
    for (int n = 0; n < `RXS_LINKS; n++) begin
      if (hit_float[n]) begin
        rd_word[`RXS_FLOAT_BIT] = float_q[n];
      end
    end
  end

  always_comb begin
    mode_d = mode_q;
    shared_d = shared_q;
    float_d = float_q;
    seen_clr = 4'h0;
    pready_d = setup;
    pslverr_d = setup & ~mapped;
    prdata_d = setup ? rd_word : 32'h0000_0000;
    if (wr && hit_cfg) begin
      case (apb_in.pwdata[`RXS_MODE_HI:`RXS_MODE_LO])
        `RXS_MODE_CODE_SLAVE: mode_d = MODE_SLAVE;
        `RXS_MODE_CODE_MUX: mode_d = MODE_MUX;
        default: mode_d = MODE_MASTER;
      endcase
      shared_d = apb_in.pwdata[`RXS_SHARED_BIT];
    end
    if (wr && hit_stat) begin
      seen_clr = apb_in.pwdata[`RXS_STAT_SEEN_HI:`RXS_STAT_SEEN_LO];
    end
    for (int n = 0; n < `RXS_LINKS; n++) begin
      if (wr && hit_float[n]) begin
        float_d[n] = apb_in.pwdata[`RXS_FLOAT_BIT];
      end
    end
    // A new clock event beats a clear in the same cycle
    seen_d = (seen_q & ~seen_clr) | act_new;
  end

  // Driver float: global pin or per-link bit
  always_comb begin
    for (int n = 0; n < `RXS_LINKS; n++) begin
      tx_oe_d[n] = ~(gfloat_s | float_q[n]);
      tx_pos_d[n] = tx_oe_d[n] & tx_line_in[n].pos;
      tx_neg_d[n] = tx_oe_d[n] & tx_line_in[n].neg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_MASTER;
      shared_q <= `RXS_SHARED_RST;
      float_q <= `RXS_FLOAT_RST;
      seen_q <= 4'h0;
      act_prev_q <= 4'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      tx_pos_q <= 4'h0;
      tx_neg_q <= 4'h0;
      tx_oe_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      shared_q <= shared_d;
      float_q <= float_d;
      seen_q <= seen_d;
      act_prev_q <= act_prev_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      tx_pos_q <= tx_pos_d;
      tx_neg_q <= tx_neg_d;
      tx_oe_q <= tx_oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign line_tx_positive = tx_pos_q;
  assign line_tx_negative = tx_neg_q;
  assign line_tx_oe = tx_oe_q;

  // ---------------- Link side, system clock domain ----------------
  // The system clock must run at a multiplexed rate
  logic lrst_meta_q;
  logic lrst_q;
  logic link_rst_n;

  // Reset asserts at once, releases on the link clock
  always_ff @(posedge mux_rx_sys_clock or negedge presetn) begin
    if (!presetn) begin
      lrst_meta_q <= 1'b0;
      lrst_q <= 1'b0;
    end else begin
      lrst_meta_q <= 1'b1;
      lrst_q <= lrst_meta_q;
    end
  end
  assign link_rst_n = lrst_q;

  logic [2:0] cfg_s;
  rx_mode_t mode_l;
  logic shared_l;
  logic [3:0] clk_s;

  // Configuration is quasi-static; per-bit sync is enough
  rx_sync2 #(.WIDTH(3)) u_cfg_sync (
    .clk(mux_rx_sys_clock),
    .rst_n(link_rst_n),
    .d({shared_q, mode_q}),
    .q(cfg_s)
  );

  rx_sync2 #(.WIDTH(4)) u_clk_sync (
    .clk(mux_rx_sys_clock),
    .rst_n(link_rst_n),
    .d(rx_sys_clock_link_in),
    .q(clk_s)
  );

  assign mode_l = rx_mode_t'(cfg_s[1:0]);
  assign shared_l = cfg_s[2];

  logic [3:0] clk_prev_q, clk_prev_d, slave_edge, mclk_q, mclk_d;
  logic [4:0] step, ser_data, ser_sig, ser_loaded;
  logic [1:0] mux_link_q, mux_link_d;
  logic [3:0] act_tgl_q, act_tgl_d, req_q, req_d;
  logic [3:0] data_q, data_d, sig_q, sig_d;
  logic [3:0] oclk_q, oclk_d, oclk_oe_q, oclk_oe_d, sys_oe_q, sys_oe_d;
  logic mux_dat_a_q, mux_dat_b_q, mux_sig_a_q, mux_sig_b_q, mux_oe_q;
  logic mux_dat_d, mux_sig_d, mux_oe_d;

  always_comb begin
    clk_prev_d = clk_s;
    slave_edge = clk_s & ~clk_prev_q;
    for (int n = 0; n < `RXS_LINKS; n++) begin
      mclk_d[n] = 1'b0;
      step[n] = 1'b0;
      case (mode_l)
        MODE_MASTER: begin
          // Clock held low through gaps
          mclk_d[n] = ~rx_gap[n] & ~mclk_q[n];
          step[n] = ~rx_gap[n] & ~mclk_q[n];
        end
        MODE_SLAVE: begin
          step[n] = shared_l ? slave_edge[0] : slave_edge[n];
        end
        default: begin
          step[n] = 1'b0;
        end
      endcase
    end
    // One bit per multiplexed clock edge
    step[4] = (mode_l == MODE_MUX);
  end

  generate
    for (gi = 0; gi <= `RXS_LINKS; gi++) begin : g_ser
      slot_t ld;
      // The last serializer carries the interleaved stream
      assign ld = (gi == `RXS_LINKS) ? slot_in[mux_link_q] :
                  slot_in[gi % `RXS_LINKS];
      rx_slot_serializer u_ser (
        .clk(mux_rx_sys_clock),
        .rst_n(link_rst_n),
        .step(step[gi]),
        .load_slot(ld),
        .data_bit(ser_data[gi]),
        .sig_bit(ser_sig[gi]),
        .loaded(ser_loaded[gi])
      );
    end
  endgenerate

  always_comb begin
    // Links one to four per slot, in order
    mux_link_d = ser_loaded[4] ? mux_link_q + 2'h1 : mux_link_q;
    for (int n = 0; n < `RXS_LINKS; n++) begin
      req_d[n] = (mode_l == MODE_MUX) ?
                 (ser_loaded[4] && mux_link_q == 2'(n)) :
                 ser_loaded[n];
      act_tgl_d[n] = act_tgl_q[n] ^ (step[n] | req_d[n]);
    end
    // Outputs retimed one link clock; master clock retimed alike
    data_d = ser_data[3:0];
    sig_d = ser_sig[3:0];
    oclk_d = mclk_q;
    oclk_oe_d = {4{mode_l == MODE_MASTER}};
    sys_oe_d = {4{mode_l != MODE_MUX}};
    mux_dat_d = ser_data[4];
    mux_sig_d = ser_sig[4];
    mux_oe_d = (mode_l == MODE_MUX);
  end

  always_ff @(posedge mux_rx_sys_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      clk_prev_q <= 4'h0;
      mclk_q <= 4'h0;
      mux_link_q <= 2'h0;
      act_tgl_q <= 4'h0;
      req_q <= 4'h0;
      data_q <= 4'h0;
      sig_q <= 4'h0;
      oclk_q <= 4'h0;
      oclk_oe_q <= 4'h0;
      sys_oe_q <= 4'h0;
      mux_dat_a_q <= 1'b0;
      mux_dat_b_q <= 1'b0;
      mux_sig_a_q <= 1'b0;
      mux_sig_b_q <= 1'b0;
      mux_oe_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      mclk_q <= mclk_d;
      mux_link_q <= mux_link_d;
      act_tgl_q <= act_tgl_d;
      req_q <= req_d;
      data_q <= data_d;
      sig_q <= sig_d;
      oclk_q <= oclk_d;
      oclk_oe_q <= oclk_oe_d;
      sys_oe_q <= sys_oe_d;
      // Backup copy from the same next value
      mux_dat_a_q <= mux_dat_d;
      mux_dat_b_q <= mux_dat_d;
      mux_sig_a_q <= mux_sig_d;
      mux_sig_b_q <= mux_sig_d;
      mux_oe_q <= mux_oe_d;
    end
  end

  rx_sync2 #(.WIDTH(4)) u_act_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(act_tgl_q),
    .q(act_s)
  );

  assign slot_req = req_q;
  assign rx_sys_data_out = data_q;
  assign rx_signaling_out = sig_q;
  assign rx_sys_clock_link = oclk_q;
  assign rx_sys_clock_oe = oclk_oe_q;
  assign rx_sys_oe = sys_oe_q;
  assign mux_rx_data_primary = mux_dat_a_q;
  assign mux_rx_data_backup = mux_dat_b_q;
  assign mux_rx_signaling_primary = mux_sig_a_q;
  assign mux_rx_signaling_backup = mux_sig_b_q;
  assign mux_rx_oe = mux_oe_q;

endmodule : rx_sys_port

/* tb/rx_sys_port_checker.sv */
// Port-level assertions for the receive system port
`timescale 1ns/1ps
module rx_sys_port_checker
  import rx_sys_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_in,
  input wire logic pready,
  input wire logic global_driver_float_pin,
  input wire logic [3:0] line_tx_positive,
  input wire logic [3:0] line_tx_negative,
  input wire logic [3:0] line_tx_oe,
  input wire logic mux_rx_sys_clock,
  input wire logic [3:0] rx_sys_clock_link,
  input wire logic [3:0] rx_sys_clock_oe,
  input wire logic [3:0] rx_gap,
  input wire slot_t [3:0] slot_in,
  input wire logic [3:0] slot_req,
  input wire logic [3:0] rx_sys_data_out,
  input wire logic [3:0] rx_sys_oe,
  input wire logic mux_rx_data_primary,
  input wire logic mux_rx_data_backup,
  input wire logic mux_rx_signaling_primary,
  input wire logic mux_rx_signaling_backup,
  input wire logic mux_rx_oe
);
  sequence next_slot_s;
    mux_rx_oe [*8];
  endsequence
  sequence sig_pad_s;
    !mux_rx_signaling_primary [*4];
  endsequence

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    apb_in.psel && !apb_in.penable |=> pready)
    else $error("no ready after setup");
  a_global_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    global_driver_float_pin [*4] |-> line_tx_oe == 4'h0)
    else $error("drivers not floated by pin");
  a_float_gates: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((line_tx_positive | line_tx_negative) & ~line_tx_oe) == 4'h0)
    else $error("floated link still drives");
  a_backup_same: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    {mux_rx_data_primary, mux_rx_signaling_primary}
    == {mux_rx_data_backup, mux_rx_signaling_backup})
    else $error("backup differs");
  a_mux_oe_excl: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    mux_rx_oe |-> rx_sys_oe == 4'h0)
    else $error("link pins drive in mux mode");
  a_slot_order: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    mux_rx_oe ##1 mux_rx_oe && slot_req[0] ##1 next_slot_s |-> slot_req[1])
    else $error("link two slot not next");
  a_sig_pad: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    mux_rx_oe && slot_req[1] |-> sig_pad_s)
    else $error("signaling upper bits not zero");
  a_mux_msb: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    mux_rx_oe && slot_req[1] |-> mux_rx_data_primary == slot_in[1].data[7])
    else $error("slot not sent msb first");
  a_gap_low: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    (rx_sys_clock_oe[0] && rx_gap[0]) [*3] |-> !rx_sys_clock_link[0])
    else $error("clock pulses in a gap");
  a_master_edge: assert property (
    @(posedge mux_rx_sys_clock) disable iff (!presetn)
    rx_sys_clock_oe[0] && $past(rx_sys_clock_oe[0])
    && $past(rx_sys_oe[0]) && $changed(rx_sys_data_out[0])
    |-> $rose(rx_sys_clock_link[0]))
    else $error("data moved off clock rise");
endmodule : rx_sys_port_checker

bind rx_sys_port rx_sys_port_checker u_chk (.pclk, .presetn, .apb_in,
  .pready, .global_driver_float_pin, .line_tx_positive, .line_tx_negative,
  .line_tx_oe, .mux_rx_sys_clock, .rx_sys_clock_link, .rx_sys_clock_oe,
  .rx_gap, .slot_in, .slot_req, .rx_sys_data_out, .rx_sys_oe,
  .mux_rx_data_primary, .mux_rx_data_backup, .mux_rx_signaling_primary,
  .mux_rx_signaling_backup, .mux_rx_oe);

/* tb/rx_backplane_model.sv */
// System backplane model: link clock, slot content and gaps
`timescale 1ns/1ps
module rx_backplane_model
  import rx_sys_port_pkg::*;
(
  input wire logic presetn,
  input wire logic gap_en,
  output logic mux_rx_sys_clock,
  output logic [3:0] rx_gap,
  output slot_t [3:0] slot_in
);
  logic [3:0] cnt_q;
  initial begin
    mux_rx_sys_clock = 1'b0;
    #7;
    forever #15 mux_rx_sys_clock = ~mux_rx_sys_clock;
  end
  // Distinct fixed content per link makes slot order visible
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      slot_in[n].data = 8'h1D + 8'h44 * 8'(n);
      slot_in[n].sig = 4'h6 + 4'(n);
    end
  end
  always_ff @(posedge mux_rx_sys_clock or negedge presetn) begin
    if (!presetn) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  assign rx_gap = {4{gap_en && cnt_q >= 4'hC}};
endmodule : rx_backplane_model

/* tb/rx_sys_port_tb.sv */
// Self-checking bench for the receive system port
`timescale 1ns/1ps
`include "rx_sys_port_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t mismatch", $time); end end
module rx_sys_port_tb
  import rx_sys_port_pkg::*;
;
  localparam logic [11:0] CFG_A = {`RXS_IDX_SYSCFG, 2'b00};
  localparam logic [11:0] FLT_A = {`RXS_IDX_FLOAT_BASE, 2'b00};
  localparam logic [11:0] STR_A = {`RXS_IDX_LINK_STRIDE, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0;
  apb_req_t apb_in;
  logic [31:0] prdata;
  logic pready, pslverr, global_driver_float_pin, mux_rx_sys_clock;
  line_pair_t [3:0] tx_line_in;
  logic [3:0] line_tx_positive, line_tx_negative, line_tx_oe, rx_gap;
  logic [3:0] rx_sys_clock_link_in = 4'h0, rx_sys_clock_link, rx_sys_clock_oe;
  slot_t [3:0] slot_in;
  logic [3:0] slot_req, rx_sys_data_out, rx_signaling_out, rx_sys_oe;
  logic mux_rx_data_primary, mux_rx_data_backup, mux_rx_oe;
  logic mux_rx_signaling_primary, mux_rx_signaling_backup;
  logic gap_en, slv_run;
  logic [4:0] div = 5'h00;
  logic [63:0] d, s;
  int n_mismatch = 0, n_tests = 0;

  rx_sys_port DUT (.pclk, .presetn, .apb_in, .prdata, .pready, .pslverr,
    .global_driver_float_pin, .tx_line_in, .line_tx_positive,
    .line_tx_negative, .line_tx_oe, .mux_rx_sys_clock, .rx_sys_clock_link_in,
    .rx_sys_clock_link, .rx_sys_clock_oe, .rx_gap, .slot_in, .slot_req,
    .rx_sys_data_out, .rx_signaling_out, .rx_sys_oe, .mux_rx_data_primary,
    .mux_rx_data_backup, .mux_rx_signaling_primary,
    .mux_rx_signaling_backup, .mux_rx_oe);
  rx_backplane_model u_far (.presetn, .gap_en, .mux_rx_sys_clock, .rx_gap,
    .slot_in);

  always #10 pclk = ~pclk;
  // Slow external link one clock, well under half the link clock
  always @(posedge pclk) begin
    div <= (div == 5'h0B) ? 5'h00 : div + 5'h01;
    if (div == 5'h0B) begin
      rx_sys_clock_link_in <= {3'h0, slv_run & ~rx_sys_clock_link_in[0]};
    end
  end

  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task timeout;
    n_mismatch++;
    end_of_test();
  endtask : timeout

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    // Ready, read data and error are taken at the rising edge only
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) timeout();
    r = prdata;
    e = pslverr;
    apb_in <= '0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd

  // Collects 64 bits: 0 mux pins, 1 link one master, 2 link four slave
  task automatic cap(input int src);
    int i, k;
    logic prev, now;
    prev = 1'b0;
    k = 0;
    repeat (40) @(negedge mux_rx_sys_clock);
    for (i = 0; i < 4000 && k < 64; i++) begin
      @(negedge mux_rx_sys_clock);
      now = (src == 1) ? rx_sys_clock_link[0] : rx_sys_clock_link_in[0];
      if (src == 0 || (src == 1 && prev && !now) ||
          (src == 2 && !prev && now)) begin
        d = {d[62:0], (src == 0) ? mux_rx_data_primary :
          rx_sys_data_out[(src == 1) ? 0 : 3]};
        s = {s[62:0], (src == 0) ? mux_rx_signaling_primary :
          rx_signaling_out[(src == 1) ? 0 : 3]};
        k++;
        if (src == 0) `CHK({mux_rx_data_backup, mux_rx_signaling_backup},
          {mux_rx_data_primary, mux_rx_signaling_primary})
      end
      prev = now;
    end
    if (k < 64) timeout();
  endtask : cap

  // Finds the data pattern, then demands signaling at the same offset
  task automatic judge(input logic [31:0] xd, input logic [31:0] xs);
    int k;
    k = -1;
    for (int i = 32; i >= 0; i--) if (d[i +: 32] === xd) k = i;
    `CHK(k >= 0, 1'b1)
    if (k >= 0) `CHK(s[k +: 32], xs)
  endtask : judge

  task automatic t_regs;
    rd(CFG_A, 32'h0, 1'b0);
    rd(FLT_A + STR_A, 32'h0, 1'b0);
    wr(CFG_A, 32'hFFFF_FFEE);
    rd(CFG_A, 32'h2, 1'b0);
    rd(12'h004, 32'h0, 1'b1);
  endtask : t_regs

  task automatic t_float;
    @(posedge pclk) global_driver_float_pin <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(line_tx_oe, 4'h0)
    `CHK(line_tx_positive, 4'h0)
    @(posedge pclk) global_driver_float_pin <= 1'b0;
    wr(FLT_A + STR_A + STR_A, 32'h10);
    repeat (6) @(negedge pclk);
    `CHK(line_tx_oe, 4'hB)
    `CHK(line_tx_negative, 4'hB)
    wr(FLT_A + STR_A + STR_A, 32'h0);
  endtask : t_float

  task automatic t_mux;
    cap(0);
    `CHK({mux_rx_oe, rx_sys_oe}, 5'h10)
    judge({8'h1D, 8'h61, 8'hA5, 8'hE9},
      {8'h06, 8'h07, 8'h08, 8'h09});
  endtask : t_mux

  task automatic t_master;
    wr(CFG_A, 32'h0);
    gap_en <= 1'b1;
    cap(1);
    `CHK(rx_sys_clock_oe, 4'hF)
    judge({4{8'h1D}}, {4{8'h06}});
    gap_en <= 1'b0;
  endtask : t_master

  task automatic t_slave;
    wr(CFG_A, 32'h11);
    slv_run <= 1'b1;
    cap(2);
    `CHK(rx_sys_clock_oe, 4'h0)
    judge({4{8'hE9}}, {4{8'h09}});
    wr(CFG_A, 32'h01);
    cap(2);
    `CHK(d[31:0], {32{d[0]}})
    `CHK(s[31:0], {32{s[0]}})
    slv_run <= 1'b0;
  endtask : t_slave

  initial begin
    apb_in = '0;
    global_driver_float_pin = 1'b0;
    tx_line_in = '1;
    gap_en = 1'b0;
    slv_run = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_float();
    t_mux();
    t_master();
    t_slave();
    end_of_test();
  end

  initial begin
    #1500000;
    timeout();
  end
endmodule : rx_sys_port_tb
